// ### rtl/sse_regs.svh
// Register offsets, field positions and reset values of the shift and
// subtract execution unit. Included by the main design file and the bench.
// Assumes a 12-bit APB byte address and 32-bit data words.
`ifndef SSE_REGS_SVH
`define SSE_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SSE_OFF_FLAGS      12'h000
`define SSE_OFF_IRQ_STAT   12'h004
`define SSE_OFF_IRQ_MASK   12'h008
`define SSE_OFF_RESULT     12'h00C
`define SSE_OFF_STATE      12'h010
`define SSE_OFF_GPR_BASE   12'h400

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SSE_IRQ_TRAP       0
`define SSE_IRQ_ILLEGAL    1
`define SSE_IRQ_DONE       2
`define SSE_IRQ_BITS       3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SSE_RST_FLAGS      4'h0
`define SSE_RST_MASK       3'h0
`define SSE_RST_WORD       32'h0000_0000

`endif

// ### rtl/sse_pkg.sv
// Types shared by the shift and subtract execution unit.
// Assumes nothing of its surroundings.
package sse_pkg;

    // ----------------------------------------------------------------
    // Instruction word and status flags
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] opcode;              // Bit 0 picks the immediate
        logic [7:0] destination_field;   // Result target register
        logic [7:0] first_source_field;  // First operand register
        logic [7:0] second_source_field; // Second register or immediate
    } sse_instr_s;

    typedef struct packed {
        logic v;  // Signed overflow
        logic n;  // Negative
        logic z;  // Zero
        logic c;  // Carry, meaning no borrow
    } sse_flags_s;

    // ----------------------------------------------------------------
    // Operations and states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ILLEGAL_OP                       = 4'b0000,
        ARITH_RIGHT_SHIFT_OP             = 4'b0001,
        LOGIC_RIGHT_SHIFT_OP             = 4'b0010,
        SUBTRACT_OP                      = 4'b0011,
        SUBTRACT_CARRY_OP                = 4'b0100,
        SUBTRACT_CARRY_SIGNED_CHECK_OP   = 4'b0101,
        SUBTRACT_CARRY_UNSIGNED_CHECK_OP = 4'b0110,
        REVERSE_SUBTRACT_OP              = 4'b0111,
        REVERSE_SUBTRACT_CARRY_OP        = 4'b1000,
        REVERSE_CARRY_SIGNED_CHECK_OP    = 4'b1001,
        REVERSE_CARRY_UNSIGNED_CHECK_OP  = 4'b1010
    } sse_op_e;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } sse_state_e;

    // Opcode to operation; bit 0 only selects the operand source
    function automatic sse_op_e sse_decode(input logic [7:0] opcode);
        case (opcode[7:1])
            7'h43:   sse_decode = ARITH_RIGHT_SHIFT_OP;
            7'h41:   sse_decode = LOGIC_RIGHT_SHIFT_OP;
            7'h12:   sse_decode = SUBTRACT_OP;
            7'h16:   sse_decode = SUBTRACT_CARRY_OP;
            7'h14:   sse_decode = SUBTRACT_CARRY_SIGNED_CHECK_OP;
            7'h15:   sse_decode = SUBTRACT_CARRY_UNSIGNED_CHECK_OP;
            7'h1A:   sse_decode = REVERSE_SUBTRACT_OP;
            7'h1E:   sse_decode = REVERSE_SUBTRACT_CARRY_OP;
            7'h1C:   sse_decode = REVERSE_CARRY_SIGNED_CHECK_OP;
            7'h1D:   sse_decode = REVERSE_CARRY_UNSIGNED_CHECK_OP;
            default: sse_decode = ILLEGAL_OP;
        endcase
    endfunction : sse_decode

endpackage : sse_pkg

// ### rtl/sse_regfile.sv
// General register file: two registered read ports, one write port.
// Assumes a single clock; a write and a read of the same entry at one
// edge return the old value.
module sse_regfile #(
    parameter int AW = 8,
    parameter int DW = 32
) (
    // Clock and enable
    input  wire logic          clk_in,
    input  wire logic          ce_in,
    // Read ports
    input  wire logic [AW-1:0] rd_a_addr_in,
    input  wire logic [AW-1:0] rd_b_addr_in,
    output logic      [DW-1:0] rd_a_data_out,
    output logic      [DW-1:0] rd_b_data_out,
    // Write port
    input  wire logic          wr_en_in,
    input  wire logic [AW-1:0] wr_addr_in,
    input  wire logic [DW-1:0] wr_data_in
);
    logic [DW-1:0] mem [0:(1<<AW)-1];  // Storage, no reset on purpose

    // Write first in program order, reads always registered
    always_ff @(posedge clk_in) begin
        if (ce_in) begin
            if (wr_en_in) begin
                mem[wr_addr_in] <= wr_data_in;
            end
            rd_a_data_out <= mem[rd_a_addr_in];
            rd_b_data_out <= mem[rd_b_addr_in];
        end
    end
endmodule : sse_regfile

// ### rtl/sse_addsub.sv
// Adder core: a + b + cin, with carry out and signed overflow.
// Assumes the caller inverts the subtrahend itself.
module sse_addsub #(
    parameter int W = 32
) (
    // Operands
    input  wire logic [W-1:0] a_in,
    input  wire logic [W-1:0] b_in,
    input  wire logic         cin_in,
    // Results
    output logic      [W-1:0] sum_out,
    output logic              cout_out,
    output logic              ovf_out
);
    logic [W:0] full;  // Sum with carry bit

    assign full     = {1'b0, a_in} + {1'b0, b_in} + {{W{1'b0}}, cin_in};
    assign sum_out  = full[W-1:0];
    assign cout_out = full[W];
    // Like signs in, other sign out
    assign ovf_out  = (a_in[W-1] == b_in[W-1]) && (full[W-1] != a_in[W-1]);
endmodule : sse_addsub

// ### rtl/sse_exec.sv
// Shift and subtract execution unit with APB register slave.
// Assumes instruction issue and APB come from logic on CLK_IN.
//
// How it works
// - Arithmetic right shift fills with sign bit
// - Logical right shift fills with zeros
// - Shift amount is low five operand bits
// - Opcode bit zero selects zero-extended immediate
// - Subtract adds two's complement, never traps
// - Carry subtract adds complement plus carry
// - Reverse subtract: second minus first operand
// - Reverse carry subtract uses complement plus carry
// - Signed-check variants trap on signed overflow
// - Unsigned-check variants trap without carry out
// - Result written even when trap taken
//
// The address map and the APB slave port were left to the implementer.
`include "sse_regs.svh"

module sse_exec (
    // Clock, reset, enable
    input  wire logic              CLK_IN,
    input  wire logic              RESET_N_IN,
    input  wire logic              CE_IN,
    // Instruction issue
    input  wire logic              INSTR_VALID_IN,
    input  wire sse_pkg::sse_instr_s INSTR_IN,
    output logic                   INSTR_READY_OUT,
    // Execution results
    output logic                   RESULT_VALID_OUT,
    output logic            [31:0] RESULT_OUT,
    output logic                   TRAP_OUT,
    output logic                   IRQ_OUT,
    // APB slave
    input  wire logic              PSEL_IN,
    input  wire logic              PENABLE_IN,
    input  wire logic              PWRITE_IN,
    input  wire logic       [11:0] PADDR_IN,
    input  wire logic       [31:0] PWDATA_IN,
    output logic            [31:0] PRDATA_OUT,
    output logic                   PREADY_OUT,
    output logic                   PSLVERR_OUT
);
    import sse_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    sse_state_e          state;        // Issue state
    sse_state_e          next_state;   // Following state
    sse_instr_s          ins_q;        // Instruction being executed
    sse_flags_s          flags;        // Arithmetic status
    logic [`SSE_IRQ_BITS-1:0] irq_stat; // Sticky events
    logic [`SSE_IRQ_BITS-1:0] irq_mask; // Event enables

    // ----------------------------------------------------------------
    // Issue control
    // ----------------------------------------------------------------
    wire accept    = CE_IN && (state == ST_IDLE) && INSTR_VALID_IN;
    wire exec_fire = CE_IN && (state == ST_EXEC);

    // One instruction in flight; no forwarding needed
    always_comb begin
        case (state)
            ST_IDLE: next_state = accept ? ST_EXEC : ST_IDLE;
            ST_EXEC: next_state = CE_IN ? ST_IDLE : ST_EXEC;
            default: next_state = ST_IDLE;
        endcase
    end

    // State, ready flag and captured instruction
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            state           <= ST_IDLE;
            INSTR_READY_OUT <= 1'b1;
            ins_q           <= '0;
        end else if (CE_IN) begin
            state           <= next_state;
            INSTR_READY_OUT <= (next_state == ST_IDLE);
            if (accept) begin
                ins_q <= INSTR_IN;
            end
        end
    end

    // ----------------------------------------------------------------
    // Operands
    // ----------------------------------------------------------------
    logic [31:0] rd_a;  // First source register contents
    logic [31:0] rd_b;  // Second source register contents
    logic        wb_en; // Result write to register file
    logic [31:0] alu_result; // Value for the destination
    logic        gpr_wr; // Software write to register file

    // field decode
    // Source register addresses taken straight from the issued word
    sse_regfile #(
        .AW (8),
        .DW (32)
    ) u_regfile (
        .clk_in        (CLK_IN),
        .ce_in         (CE_IN),
        .rd_a_addr_in  (INSTR_IN.first_source_field),
        .rd_b_addr_in  (INSTR_IN.second_source_field),
        .rd_a_data_out (rd_a),
        .rd_b_data_out (rd_b),
        .wr_en_in      (wb_en | gpr_wr),
        .wr_addr_in    (wb_en ? ins_q.destination_field : PADDR_IN[9:2]),
        .wr_data_in    (wb_en ? alu_result : PWDATA_IN)
    );

    sse_op_e     op;           // Decoded operation
    logic [31:0] op_a;         // First operand
    logic [31:0] second_operand_val;     // Second operand
    logic [4:0]  shamt;        // Shift distance
    logic        is_shift;     // Either right shift
    logic        is_rev;       // Reverse operand order
    logic        use_carry;    // Carry-in from status
    logic        chk_signed;   // Signed trap check
    logic        chk_unsigned; // Unsigned trap check

    assign op   = sse_decode(ins_q.opcode);
    assign op_a = rd_a;
    assign second_operand_val = ins_q.opcode[0] ? {24'h00_0000, ins_q.second_source_field} : rd_b;
    assign shamt    = second_operand_val[4:0];

    assign is_shift = (op == ARITH_RIGHT_SHIFT_OP) || (op == LOGIC_RIGHT_SHIFT_OP);
    assign is_rev   = (op == REVERSE_SUBTRACT_OP) || (op == REVERSE_SUBTRACT_CARRY_OP)
                   || (op == REVERSE_CARRY_SIGNED_CHECK_OP)
                   || (op == REVERSE_CARRY_UNSIGNED_CHECK_OP);
    assign use_carry = (op == SUBTRACT_CARRY_OP) || (op == SUBTRACT_CARRY_SIGNED_CHECK_OP)
                    || (op == SUBTRACT_CARRY_UNSIGNED_CHECK_OP)
                    || (op == REVERSE_SUBTRACT_CARRY_OP)
                    || (op == REVERSE_CARRY_SIGNED_CHECK_OP)
                    || (op == REVERSE_CARRY_UNSIGNED_CHECK_OP);
    assign chk_signed   = (op == SUBTRACT_CARRY_SIGNED_CHECK_OP)
                       || (op == REVERSE_CARRY_SIGNED_CHECK_OP);
    assign chk_unsigned = (op == SUBTRACT_CARRY_UNSIGNED_CHECK_OP)
                       || (op == REVERSE_CARRY_UNSIGNED_CHECK_OP);

    // ----------------------------------------------------------------
    // Datapath
    // ----------------------------------------------------------------
    logic [31:0] minuend;    // Left side of the difference
    logic [31:0] subtrahend; // Right side of the difference
    logic [31:0] sum;        // Adder result
    logic        cout;       // Carry out, no borrow
    logic        ovf;        // Signed overflow
    logic [31:0] sra_val;    // Sign-filled shift
    logic [31:0] srl_val;    // Zero-filled shift
    logic        trap;       // Out-of-range event

    assign minuend    = is_rev ? second_operand_val : op_a;
    assign subtrahend = is_rev ? op_a : second_operand_val;

    // complement adder
    // Two's complement is the one's complement with carry-in forced high
    sse_addsub #(
        .W (32)
    ) u_addsub (
        .a_in     (minuend),
        .b_in     (~subtrahend),
        .cin_in   (use_carry ? flags.c : 1'b1),
        .sum_out  (sum),
        .cout_out (cout),
        .ovf_out  (ovf)
    );

    assign sra_val = $signed(op_a) >>> shamt;
    assign srl_val = op_a >> shamt;

    assign alu_result = (op == ARITH_RIGHT_SHIFT_OP) ? sra_val :
                        (op == LOGIC_RIGHT_SHIFT_OP) ? srl_val : sum;

    // range traps
    // Plain and non-checking forms never trap
    assign trap = (chk_signed && ovf) || (chk_unsigned && !cout);

    // unconditional writeback
    // Destination written whether or not the trap is taken
    assign wb_en = exec_fire && (op != ILLEGAL_OP);

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;   // Read data selection
    logic        mapped;   // Address decodes
    logic        read_only; // Write to the result or state register

    wire apb_acc  = PSEL_IN && PENABLE_IN && !PREADY_OUT;
    wire apb_xfer = CE_IN && PSEL_IN && PENABLE_IN && PREADY_OUT;
    wire gpr_sel  = (PADDR_IN[11:10] == 2'(`SSE_OFF_GPR_BASE >> 10));
    wire wr_xfer  = apb_xfer && PWRITE_IN;
    // Software writes to the register file are write only
    assign gpr_wr = wr_xfer && gpr_sel;

    assign mapped = gpr_sel ? PWRITE_IN :
                    (PADDR_IN == `SSE_OFF_FLAGS) || (PADDR_IN == `SSE_OFF_IRQ_STAT)
                 || (PADDR_IN == `SSE_OFF_IRQ_MASK) || (PADDR_IN == `SSE_OFF_RESULT)
                 || (PADDR_IN == `SSE_OFF_STATE);
    assign read_only = PWRITE_IN && ((PADDR_IN == `SSE_OFF_RESULT)
                    || (PADDR_IN == `SSE_OFF_STATE));

    assign rd_mux = (PADDR_IN == `SSE_OFF_FLAGS)    ? {28'h000_0000, flags} :
                    (PADDR_IN == `SSE_OFF_IRQ_STAT) ? {29'h0000_0000, irq_stat} :
                    (PADDR_IN == `SSE_OFF_IRQ_MASK) ? {29'h0000_0000, irq_mask} :
                    (PADDR_IN == `SSE_OFF_RESULT)   ? RESULT_OUT :
                    (PADDR_IN == `SSE_OFF_STATE)    ? {31'h0000_0000, state} :
                    `SSE_RST_WORD;

    // A register file write waits while a result writeback is due,
    // so the single write port never sees two writers at once
    wire next_pready = apb_acc && !(gpr_sel && PWRITE_IN && next_state == ST_EXEC);

    // Answer one cycle into the access phase at the earliest
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            PREADY_OUT  <= 1'b0;
            PRDATA_OUT  <= `SSE_RST_WORD;
            PSLVERR_OUT <= 1'b0;
        end else if (CE_IN) begin
            PREADY_OUT  <= next_pready;
            PRDATA_OUT  <= next_pready && !PWRITE_IN ? rd_mux : `SSE_RST_WORD;
            PSLVERR_OUT <= next_pready && (!mapped || read_only);
        end
    end

    // ----------------------------------------------------------------
    // Status flags, results and interrupts
    // ----------------------------------------------------------------
    wire flags_wr = wr_xfer && (PADDR_IN == `SSE_OFF_FLAGS);
    wire stat_rd  = apb_xfer && !PWRITE_IN && (PADDR_IN == `SSE_OFF_IRQ_STAT);

    logic [`SSE_IRQ_BITS-1:0] events;  // This cycle's events
    assign events[`SSE_IRQ_TRAP]    = exec_fire && trap;
    assign events[`SSE_IRQ_ILLEGAL] = exec_fire && (op == ILLEGAL_OP);
    assign events[`SSE_IRQ_DONE]    = wb_en;

    // Flags; a subtract beats a software write in the same cycle
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            flags <= `SSE_RST_FLAGS;
        end else if (wb_en && !is_shift) begin
            flags <= '{v: ovf, n: sum[31], z: (sum == 32'h0000_0000), c: cout};
        end else if (flags_wr) begin
            flags <= PWDATA_IN[3:0];
        end
    end

    // Result register and one-cycle strobes
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            RESULT_OUT       <= `SSE_RST_WORD;
            RESULT_VALID_OUT <= 1'b0;
            TRAP_OUT         <= 1'b0;
        end else if (CE_IN) begin
            RESULT_VALID_OUT <= wb_en;
            TRAP_OUT         <= events[`SSE_IRQ_TRAP];
            if (wb_en) begin
                RESULT_OUT <= alu_result;
            end
        end
    end

    // Sticky status cleared by read; a new event wins over the clear.
    // Only bits already shown in the read data are cleared, so an event
    // landing during the access phase is never lost.
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            irq_stat <= '0;
            irq_mask <= `SSE_RST_MASK;
            IRQ_OUT  <= 1'b0;
        end else if (CE_IN) begin
            irq_stat <= (stat_rd ? irq_stat & ~PRDATA_OUT[`SSE_IRQ_BITS-1:0] : irq_stat)
                      | events;
            if (wr_xfer && PADDR_IN == `SSE_OFF_IRQ_MASK) begin
                irq_mask <= PWDATA_IN[`SSE_IRQ_BITS-1:0];
            end
            IRQ_OUT  <= |(irq_stat & irq_mask);
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    // Independent reference for the sign-filled shift
    wire [31:0] sra_ref = op_a[31] ? ~(~op_a >> shamt) : (op_a >> shamt);
    sequence fire_s(sse_op_e k);
        exec_fire && op == k;
    endsequence

    arith_shift_fill_a: assert property (
        fire_s(ARITH_RIGHT_SHIFT_OP) |=> RESULT_OUT == $past(sra_ref))
        else $error("arithmetic shift fill wrong");
    logic_shift_fill_a: assert property (
        fire_s(LOGIC_RIGHT_SHIFT_OP) |=> RESULT_OUT == ($past(op_a) >> $past(second_operand_val[4:0])))
        else $error("logical shift result wrong");
    imm_operand_a: assert property (
        exec_fire && ins_q.opcode[0] |-> second_operand_val[31:8] == 24'h00_0000)
        else $error("immediate not zero extended");
    plain_sub_a: assert property (
        fire_s(SUBTRACT_OP) |=> RESULT_OUT == $past(op_a - second_operand_val) && !TRAP_OUT)
        else $error("plain subtract wrong");
    carry_sub_a: assert property (
        fire_s(SUBTRACT_CARRY_OP) |=>
            RESULT_OUT == $past(op_a + ~second_operand_val + {31'h0000_0000, flags.c}))
        else $error("carry subtract wrong");
    reverse_sub_a: assert property (
        fire_s(REVERSE_SUBTRACT_OP) |=> RESULT_OUT == $past(second_operand_val - op_a))
        else $error("reverse subtract wrong");
    signed_trap_a: assert property (
        exec_fire && chk_signed && ovf |=> TRAP_OUT && irq_stat[`SSE_IRQ_TRAP])
        else $error("signed trap missed");
    unsigned_trap_a: assert property (
        exec_fire && chk_unsigned |=> TRAP_OUT == !$past(cout))
        else $error("unsigned trap wrong");
    trap_writes_a: assert property (
        TRAP_OUT |-> RESULT_VALID_OUT)
        else $error("trap without result write");
    shift_flags_a: assert property (
        exec_fire && is_shift && !flags_wr |=> $stable(flags))
        else $error("shift changed flags");
endmodule : sse_exec

// ### verification/tb_top.sv
// Self-checking bench for the shift and subtract execution unit.
// Assumes the unit's assertions live in its own files; the bench drives
// the APB and issue ports itself and keeps a reference model.
`include "sse_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import sse_pkg::*;
    // ------------------------------------------------------------
    // Stimulus, responses and model state
    // ------------------------------------------------------------
    logic        clk = 0, rst_n = 0, ivalid = 0, psel = 0, pen = 0, pwr = 0;
    logic        ce = 1;                 // Clock enable to the unit
    sse_instr_s  instr = '0;             // Offered instruction word
    logic [11:0] paddr = '0;             // APB byte address
    logic [31:0] pwdata = '0;            // APB write data
    logic        irdy, rvalid, trap, irq, pready, pslverr;
    logic [31:0] result, prdata;
    logic [31:0] regs [8];               // Model of the used registers
    logic [3:0]  flg;                    // Model flags {V,N,Z,C}
    logic [2:0]  stat, mask;             // Model interrupt status and mask
    logic [31:0] lfsr, t;                // Random source and scratch
    int          err_count = 0, cmp_count = 0;
    logic [7:0]  ops [10] = '{8'h86, 8'h82, 8'h24, 8'h2C, 8'h28,
                              8'h2A, 8'h34, 8'h3C, 8'h38, 8'h3A};
    // Free-running core clock, 25 ns period
    always #12.5 clk = ~clk;
    sse_exec i_dut (.CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce),
        .INSTR_VALID_IN(ivalid), .INSTR_IN(instr), .INSTR_READY_OUT(irdy),
        .RESULT_VALID_OUT(rvalid), .RESULT_OUT(result), .TRAP_OUT(trap),
        .IRQ_OUT(irq), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Shift register source; same seed every run
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C1_1DB7 : 32'h0000_0000);
        return lfsr;
    endfunction : rnd
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask : chk_bit
    // One APB transfer; waits on ready, bounded by the watchdog
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0; pen <= 0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, d, rd, er);
        chk_bit(er, e);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic e);
        logic [31:0] rdv;
        logic        er;
        apb(1'b0, a, 32'h0000_0000, rdv, er);
        chk_bit(er, e);
        if (!e) chk_word(rdv, exp);
    endtask : rd
    // Model and issue one instruction, then check its outcome
    task automatic run(input logic [7:0] op, dst, ra, rb, input logic bad);
        logic [31:0] a, b, x, y, r;
        logic [32:0] s;
        logic        v, tr;
        int          n;
        a = regs[ra[2:0]];
        b = op[0] ? {24'h0000_00, rb} : regs[rb[2:0]];
        tr = 0;
        r = 0;
        if (op[7:1] == 7'h43) r = $signed(a) >>> b[4:0];
        else if (op[7:1] == 7'h41) r = a >> b[4:0];
        else if (!bad) begin
            x = op[4] ? b : a;
            y = op[4] ? a : b;
            s = {1'b0, x} + {1'b0, ~y} + ((op[3:1] == 3'b010) ? 33'h1 : {32'h0, flg[0]});
            r = s[31:0];
            v = (x[31] != y[31]) && (r[31] != x[31]);
            tr = (op[3:1] == 3'b100 && v) || (op[3:1] == 3'b101 && !s[32]);
            flg = {v, r[31], r == 32'h0000_0000, s[32]};
        end
        @(posedge clk);
        ivalid <= 1;
        instr <= {op, dst, ra, rb};
        do @(posedge clk); while (irdy !== 1'b1);
        ivalid <= 0;
        n = 0;
        do begin @(negedge clk); n++; end while (rvalid !== 1'b1 && n < 8);
        chk_bit(rvalid, !bad);
        if (!bad) begin
            chk_word(result, r);
            chk_bit(trap, tr);
            regs[dst[2:0]] = r;
        end
        stat = stat | (bad ? 3'b010 : {2'b10, tr});
        rd(`SSE_OFF_FLAGS, {28'h0, flg}, 0);
        chk_bit(irq, |(stat & mask));
    endtask : run
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        lfsr = 32'h7217_94BF;
        stat = 0;
        mask = 3'b001;
        flg = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1;
        rd(`SSE_OFF_FLAGS, 32'h0000_0000, 0);
        rd(`SSE_OFF_IRQ_MASK, 32'h0000_0000, 0);
        rd(`SSE_OFF_STATE, 32'h0000_0000, 0);
        // Unmapped, read-only and write-only places are refused
        rd(12'h100, 32'h0000_0000, 1);
        wr(`SSE_OFF_RESULT, 32'h0000_0001, 1);
        rd(`SSE_OFF_GPR_BASE, 32'h0000_0000, 1);
        $display("test reset and map done");
        // Boundary operands first, random ones after
        regs = '{32'h8000_0000, 32'h7FFF_FFFF, 32'h0000_0000, 32'hFFFF_FFFF,
                 rnd(), rnd(), rnd(), rnd()};
        for (int i = 0; i < 8; i++) wr(`SSE_OFF_GPR_BASE + 12'(4 * i), regs[i], 0);
        wr(`SSE_OFF_IRQ_MASK, {29'h0, mask}, 0);
        // Every operation, register and immediate forms, chained results
        for (int k = 0; k < 8; k++) begin
            for (int o = 0; o < 10; o++) begin
                t = rnd();
                flg = t[3:0];
                wr(`SSE_OFF_FLAGS, {28'h0, flg}, 0);
                t = rnd();
                // Register forms name only the eight loaded registers
                run(ops[o] | 8'(k[0]), {5'h0, t[2:0]}, {5'h0, t[10:8]},
                    k[0] ? t[23:16] : {5'h0, t[18:16]}, 0);
            end
        end
        $display("test operations done");
        // Read clears status; illegal code raises its own bit
        rd(`SSE_OFF_IRQ_STAT, {29'h0, stat}, 0);
        stat = 0;
        rd(`SSE_OFF_IRQ_STAT, 32'h0000_0000, 0);
        chk_bit(irq, 1'b0);
        mask = 3'b010;
        wr(`SSE_OFF_IRQ_MASK, {29'h0, mask}, 0);
        run(8'h20, 8'h01, 8'h02, 8'h03, 1);
        rd(`SSE_OFF_IRQ_STAT, 32'h0000_0002, 0);
        stat = 0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk_bit(irq, 1'b0);
        // Enable low freezes the unit: a held offer is never taken
        t = result;
        @(posedge clk);
        ce <= 0;
        ivalid <= 1;
        instr <= {8'h25, 8'h00, 8'h01, 8'h07};
        repeat (4) @(posedge clk);
        chk_bit(irdy, 1'b1);
        chk_bit(rvalid, 1'b0);
        ivalid <= 0;
        ce <= 1;
        repeat (3) @(posedge clk);
        chk_word(result, t);
        $display("test interrupts done");
        conclude();
    end
    // Cuts a hang short well past the expected run length
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        conclude();
    end
endmodule : tb_top
